// *** src/input_select_and_stb_diag.sv ***
// Input format routing and short-to-battery sense logic
`timescale 1ns/1ps
`default_nettype none

module input_select_and_stb_diag #(
    parameter int SIX_INPUTS = 0 // 1 selects the six-input variant
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic clk_en, // Clock enable, freezes state when low
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [7:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    output logic [7:0] reg_rdata, // Register read data
    output logic reg_rvalid, // Read data valid pulse
    input wire logic sense_a_above, // Comparator A, asynchronous
    input wire logic sense_b_above, // Comparator B, asynchronous
    output logic [5:0] analog_input_power, // Per-input power, 1 = on
    output logic [2:0] video_processor_core, // Processing format
    output logic [2:0] luma_input, // Luma or composite input index
    output logic [2:0] chroma_input, // Chroma or negative input index
    output logic [2:0] aux_input, // Third component input index
    output logic sense_a_power_down, // Comparator A power-down
    output logic sense_b_power_down, // Comparator B power-down
    output logic [2:0] sense_a_threshold, // Comparator A threshold code
    output logic [2:0] sense_b_threshold, // Comparator B threshold code
    output logic interrupt_request_n // Interrupt, active low
);
    import input_select_pkg::*;

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [FMT_W-1:0] input_format_select;
    logic [1:0] sense_enable;
    logic [1:0] battery_short;
    logic [1:0] sync_1;
    logic [1:0] sync_2;
    logic [5:0] next_power;
    video_format_e next_format;
    logic [2:0] next_luma;
    logic [2:0] next_chroma;
    logic [2:0] next_aux;
    logic [1:0] trip;
    logic [1:0] clear_req;

    // Only the low five bits are stored; the rest read as zero
    // selector register write
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            input_format_select <= FMT_RESET;
        end else if (clk_en && reg_wr && reg_addr == ADDR_INPUT_FORMAT) begin
            input_format_select <= reg_wdata[FMT_LSB +: FMT_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sense_a_power_down <= PWRDN_RESET;
            sense_b_power_down <= PWRDN_RESET;
            sense_a_threshold <= THRESH_RESET;
            sense_b_threshold <= THRESH_RESET;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == ADDR_SENSE_A) begin
                sense_a_power_down <= reg_wdata[PWRDN_BIT];
                sense_a_threshold <= reg_wdata[THRESH_LSB +: THRESH_W];
            end else if (reg_addr == ADDR_SENSE_B) begin
                sense_b_power_down <= reg_wdata[PWRDN_BIT];
                sense_b_threshold <= reg_wdata[THRESH_LSB +: THRESH_W];
            end
        end
    end

    // Software must set these bits before any trip is recorded
    // diagnostic enable, off after reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sense_enable <= 2'h0;
        end else if (clk_en && reg_wr && reg_addr == ADDR_SENSE_ENABLE) begin
            sense_enable <= reg_wdata[1:0];
        end
    end

    // ****************************************************************
    // Format decode
    // ****************************************************************
    // fixed routing per code
    always_comb begin
        next_power = 6'h00;
        next_format = FMT_NONE;
        next_luma = 3'h0;
        next_chroma = 3'h0;
        next_aux = 3'h0;
        case (input_format_select)
            // composite on one input each: 1 to 6, or 1 to 4 in the four-input variant
            SEL_CVBS1: begin
                next_format = FMT_COMPOSITE;
                next_luma = 3'h1;
            end
            SEL_CVBS2: begin
                next_format = FMT_COMPOSITE;
                next_luma = 3'h2;
            end
            SEL_CVBS3: begin
                if (SIX_INPUTS != 0) begin
                    next_format = FMT_COMPOSITE;
                    next_luma = 3'h3;
                end
            end
            SEL_CVBS4: begin
                if (SIX_INPUTS != 0) begin
                    next_format = FMT_COMPOSITE;
                    next_luma = 3'h4;
                end
            end
            SEL_CVBS5: begin
                next_format = FMT_COMPOSITE;
                next_luma = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
            end
            SEL_CVBS6: begin
                next_format = FMT_COMPOSITE;
                next_luma = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
            end
            SEL_YC12: begin
                next_format = FMT_SVIDEO;
                next_luma = 3'h1;
                next_chroma = 3'h2;
            end
            SEL_YC34: begin
                if (SIX_INPUTS != 0) begin
                    next_format = FMT_SVIDEO;
                    next_luma = 3'h3;
                    next_chroma = 3'h4;
                end
            end
            SEL_YC56: begin
                next_format = FMT_SVIDEO;
                next_luma = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
                next_chroma = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
            end
            SEL_YPBPR: begin
                if (SIX_INPUTS != 0) begin
                    next_format = FMT_COMPONENT;
                    next_luma = 3'h1;
                    next_chroma = 3'h2;
                    next_aux = 3'h3;
                end
            end
            SEL_DIFF12: begin
                next_format = FMT_DIFF_COMPOSITE;
                next_luma = 3'h1;
                next_chroma = 3'h2;
            end
            SEL_DIFF34: begin
                if (SIX_INPUTS != 0) begin
                    next_format = FMT_DIFF_COMPOSITE;
                    next_luma = 3'h3;
                    next_chroma = 3'h4;
                end
            end
            SEL_DIFF56: begin
                next_format = FMT_DIFF_COMPOSITE;
                next_luma = (SIX_INPUTS != 0) ? 3'h5 : 3'h3;
                next_chroma = (SIX_INPUTS != 0) ? 3'h6 : 3'h4;
            end
            default: begin
                next_format = FMT_NONE;
            end
        endcase
        // Power only the inputs in use
        // Index zero marks an unused slot, so it powers nothing
        for (int i = 1; i <= 6; i++) begin
            if (next_luma == 3'(i) || next_chroma == 3'(i) || next_aux == 3'(i)) begin
                next_power[i-1] = 1'b1;
            end
        end
    end

    // Routing follows the selector one clock later
    // registered routing and core format
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analog_input_power <= 6'h00;
            video_processor_core <= FMT_NONE;
            luma_input <= 3'h0;
            chroma_input <= 3'h0;
            aux_input <= 3'h0;
        end else if (clk_en) begin
            analog_input_power <= next_power;
            video_processor_core <= next_format;
            luma_input <= next_luma;
            chroma_input <= next_chroma;
            aux_input <= next_aux;
        end
    end

    // ****************************************************************
    // Sense channels
    // ****************************************************************
    // Two-stage synchroniser for comparator outputs
    // Comparator levels arrive unclocked; two flops tame metastability
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync_1 <= 2'h0;
            sync_2 <= 2'h0;
        end else if (clk_en) begin
            sync_1 <= {sense_b_above, sense_a_above};
            sync_2 <= sync_1;
        end
    end

    // trip only when powered and enabled
    assign trip = sync_2 & sense_enable & ~{sense_b_power_down, sense_a_power_down};
    // Write-one-to-clear request for the sticky status bits
    assign clear_req = (reg_wr && reg_addr == ADDR_SENSE_STATUS) ? reg_wdata[1:0] : 2'h0;

    // Each channel keeps its own bit, so both can show at once
    // independent sticky indications per channel
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_sense
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    battery_short[ch] <= 1'b0;
                end else if (clk_en) begin
                    if (trip[ch]) begin
                        battery_short[ch] <= 1'b1;
                    end else if (clear_req[ch]) begin
                        battery_short[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Registered so the pin comes straight from a flop
    // interrupt while any enabled indication set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            interrupt_request_n <= 1'b1;
        end else if (clk_en) begin
            interrupt_request_n <= ~|(battery_short & sense_enable);
        end
    end

    // ****************************************************************
    // Register readback
    // ****************************************************************
    // Read data idles at zero outside a read
    // status readback shows tripped channel
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (!reg_rd) begin
                reg_rdata <= 8'h00;
            end else if (reg_addr == ADDR_INPUT_FORMAT) begin
                reg_rdata <= {3'h0, input_format_select};
            end else if (reg_addr == ADDR_SENSE_A) begin
                reg_rdata <= {1'b0, sense_a_power_down, 1'b0, sense_a_threshold, 2'h0};
            end else if (reg_addr == ADDR_SENSE_B) begin
                reg_rdata <= {1'b0, sense_b_power_down, 1'b0, sense_b_threshold, 2'h0};
            end else if (reg_addr == ADDR_SENSE_STATUS) begin
                reg_rdata <= {6'h00, battery_short};
            end else if (reg_addr == ADDR_SENSE_ENABLE) begin
                reg_rdata <= {6'h00, sense_enable};
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

endmodule

`default_nettype wire

// *** src/input_select_pkg.sv ***
// Package: register map, field positions, reset values and format codes
package input_select_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_INPUT_FORMAT = 8'h00;
    localparam logic [7:0] ADDR_SENSE_A = 8'h5d;
    localparam logic [7:0] ADDR_SENSE_B = 8'h5e;
    localparam logic [7:0] ADDR_SENSE_STATUS = 8'h5f;
    localparam logic [7:0] ADDR_SENSE_ENABLE = 8'h60;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int FMT_LSB = 0;
    localparam int FMT_W = 5;
    localparam int PWRDN_BIT = 6;
    localparam int THRESH_LSB = 2;
    localparam int THRESH_W = 3;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [4:0] FMT_RESET = 5'h00;
    localparam logic [2:0] THRESH_RESET = 3'h3;
    localparam logic PWRDN_RESET = 1'b1;

    // Processing formats of the video processor core
    typedef enum logic [2:0] {
        FMT_NONE = 3'b000,
        FMT_COMPOSITE = 3'b001,
        FMT_DIFF_COMPOSITE = 3'b010,
        FMT_SVIDEO = 3'b011,
        FMT_COMPONENT = 3'b100
    } video_format_e;

    // Input format select codes
    localparam logic [4:0] SEL_CVBS1 = 5'h00;
    localparam logic [4:0] SEL_CVBS2 = 5'h01;
    localparam logic [4:0] SEL_CVBS3 = 5'h02;
    localparam logic [4:0] SEL_CVBS4 = 5'h03;
    localparam logic [4:0] SEL_CVBS5 = 5'h06;
    localparam logic [4:0] SEL_CVBS6 = 5'h07;
    localparam logic [4:0] SEL_YC12 = 5'h08;
    localparam logic [4:0] SEL_YC34 = 5'h09;
    localparam logic [4:0] SEL_YC56 = 5'h0b;
    localparam logic [4:0] SEL_YPBPR = 5'h0c;
    localparam logic [4:0] SEL_DIFF12 = 5'h0e;
    localparam logic [4:0] SEL_DIFF34 = 5'h0f;
    localparam logic [4:0] SEL_DIFF56 = 5'h11;

endpackage

// *** verification/input_select_props.sv ***
// Assertion checker for the input select and battery short sense block
`timescale 1ns/1ps
`default_nettype none
module input_select_props #(
    parameter int SIX_INPUTS = 0 // Variant
) (
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic clk_en, // Enable
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [7:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic [7:0] reg_rdata, // Read data
    input wire logic reg_rvalid, // Read valid
    input wire logic sense_a_above, // Trip A
    input wire logic sense_b_above, // Trip B
    input wire logic [5:0] analog_input_power, // Power
    input wire logic [2:0] video_processor_core, // Format
    input wire logic [2:0] luma_input, // Luma
    input wire logic [2:0] chroma_input, // Chroma
    input wire logic [2:0] aux_input, // Third
    input wire logic sense_a_power_down, // Down A
    input wire logic sense_b_power_down, // Down B
    input wire logic [2:0] sense_a_threshold, // Level A
    input wire logic [2:0] sense_b_threshold, // Level B
    input wire logic interrupt_request_n // Interrupt
);
    import input_select_pkg::*;
    logic [7:0] wdata_q;
    // Keeps the last write data for field comparisons
    always_ff @(posedge clk_sys) wdata_q <= reg_wdata;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    property p_read_valid;
        clk_en && reg_rd |=> reg_rvalid;
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read not answered");
    property p_sense_a;
        clk_en && reg_wr && reg_addr == ADDR_SENSE_A |=> sense_a_power_down == wdata_q[PWRDN_BIT]
            && sense_a_threshold == wdata_q[THRESH_LSB +: THRESH_W];
    endproperty
    a_sense_a: assert property (p_sense_a) else $error("sense a fields wrong");
    property p_sense_b;
        clk_en && reg_wr && reg_addr == ADDR_SENSE_B |=> sense_b_power_down == wdata_q[PWRDN_BIT]
            && sense_b_threshold == wdata_q[THRESH_LSB +: THRESH_W];
    endproperty
    a_sense_b: assert property (p_sense_b) else $error("sense b fields wrong");
    property p_reset_cfg;
        $fell(rst) |-> sense_a_power_down && sense_b_power_down && interrupt_request_n
            && sense_a_threshold == THRESH_RESET && sense_b_threshold == THRESH_RESET;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("reset state wrong");
    property p_svideo;
        (clk_en && reg_wr && reg_addr == ADDR_INPUT_FORMAT && reg_wdata[4:0] == SEL_YC56) ##1 clk_en
            |=> luma_input == (SIX_INPUTS ? 3'h5 : 3'h3)
            && chroma_input == (SIX_INPUTS ? 3'h6 : 3'h4)
            && video_processor_core == FMT_SVIDEO && aux_input == 3'h0;
    endproperty
    a_svideo: assert property (p_svideo) else $error("s-video routing wrong");
    property p_reserved_off;
        video_processor_core == FMT_NONE |-> analog_input_power == 6'h00 && luma_input == 3'h0;
    endproperty
    a_reserved_off: assert property (p_reserved_off) else $error("idle inputs powered");
    property p_composite;
        video_processor_core == FMT_COMPOSITE |-> $onehot(analog_input_power) && chroma_input == 3'h0;
    endproperty
    a_composite: assert property (p_composite) else $error("composite power wrong");
    property p_irq_quiet;
        (sense_a_power_down && sense_b_power_down && !reg_wr)[*3] ##0 interrupt_request_n
            |=> interrupt_request_n;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt while powered down");
endmodule
bind input_select_and_stb_diag input_select_props #(.SIX_INPUTS(SIX_INPUTS)) i_input_select_props (
    .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sense_a_above(sense_a_above), .sense_b_above(sense_b_above), .aux_input(aux_input),
    .analog_input_power(analog_input_power), .video_processor_core(video_processor_core),
    .luma_input(luma_input), .chroma_input(chroma_input), .sense_a_power_down(sense_a_power_down),
    .sense_b_power_down(sense_b_power_down), .sense_a_threshold(sense_a_threshold),
    .sense_b_threshold(sense_b_threshold), .interrupt_request_n(interrupt_request_n));
`default_nettype wire

// *** verification/tb_input_select_and_stb_diag.sv ***
// Self-checking bench for the input select and battery short sense block
`timescale 1ns/1ps
`default_nettype none
module tb_input_select_and_stb_diag;
    import input_select_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic sense_a_above = 1'b0, sense_b_above = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    wire logic [7:0] rdata [2];
    wire logic [5:0] pw [2];
    wire logic [2:0] core [2], li [2], ci [2], ai [2], tha [2], thb [2];
    wire logic rv [2], pda [2], pdb [2], irqn [2];
    int error_cnt = 0, num_checks = 0, cyc = 0;
    // One instance of each variant, sharing every input
    for (genvar v = 0; v < 2; v++) begin : g_var
        input_select_and_stb_diag #(.SIX_INPUTS(v)) i_input_select_and_stb_diag (
            .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
            .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata[v]), .reg_rvalid(rv[v]),
            .sense_a_above(sense_a_above), .sense_b_above(sense_b_above), .aux_input(ai[v]),
            .analog_input_power(pw[v]), .video_processor_core(core[v]), .luma_input(li[v]),
            .chroma_input(ci[v]), .sense_a_power_down(pda[v]), .sense_b_power_down(pdb[v]),
            .sense_a_threshold(tha[v]), .sense_b_threshold(thb[v]), .interrupt_request_n(irqn[v]));
    end
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [11:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        for (int v = 0; v < 2; v++) begin
            chk("valid", 12'(rv[v]), 12'h001);
            chk("rdata", 12'(rdata[v]), 12'(e));
        end
    endtask
    // Compares the comparator configuration pins of both variants
    task automatic cfg(input logic [7:0] e);
        for (int v = 0; v < 2; v++) begin
            chk("config", {4'h0, pda[v], pdb[v], tha[v], thb[v]}, {4'h0, e});
        end
    endtask
    task automatic pulse(input logic [1:0] s);
        @(negedge clk_sys);
        {sense_b_above, sense_a_above} = s;
        repeat (8) @(negedge clk_sys);
        {sense_b_above, sense_a_above} = 2'b00;
        repeat (2) @(negedge clk_sys);
    endtask
    function automatic logic [11:0] pk(logic [2:0] f, int l, int c, int a);
        return {f, 3'(l), 3'(c), 3'(a)};
    endfunction
    // Expected format and input indexes for each code and variant
    function automatic logic [11:0] exp_route(int six, logic [4:0] code);
        case (code)
            5'h00: return pk(FMT_COMPOSITE, 1, 0, 0);
            5'h01: return pk(FMT_COMPOSITE, 2, 0, 0);
            5'h02: return six ? pk(FMT_COMPOSITE, 3, 0, 0) : 12'h000;
            5'h03: return six ? pk(FMT_COMPOSITE, 4, 0, 0) : 12'h000;
            5'h06: return pk(FMT_COMPOSITE, six ? 5 : 3, 0, 0);
            5'h07: return pk(FMT_COMPOSITE, six ? 6 : 4, 0, 0);
            5'h08: return pk(FMT_SVIDEO, 1, 2, 0);
            5'h09: return six ? pk(FMT_SVIDEO, 3, 4, 0) : 12'h000;
            5'h0b: return pk(FMT_SVIDEO, six ? 5 : 3, six ? 6 : 4, 0);
            5'h0c: return six ? pk(FMT_COMPONENT, 1, 2, 3) : 12'h000;
            5'h0e: return pk(FMT_DIFF_COMPOSITE, 1, 2, 0);
            5'h0f: return six ? pk(FMT_DIFF_COMPOSITE, 3, 4, 0) : 12'h000;
            5'h11: return pk(FMT_DIFF_COMPOSITE, six ? 5 : 3, six ? 6 : 4, 0);
            default: return 12'h000;
        endcase
    endfunction
    task automatic route(input logic [4:0] c);
        logic [11:0] r;
        logic [5:0] p;
        for (int v = 0; v < 2; v++) begin
            r = exp_route(v, c);
            p = 6'h00;
            for (int k = 0; k < 3; k++) if (r[3*k +: 3] != 3'h0) p[r[3*k +: 3] - 3'h1] = 1'b1;
            chk("power", 12'(pw[v]), 12'(p));
            chk("format", 12'(core[v]), 12'(r[11:9]));
            chk("inputs", {3'h0, li[v], ci[v], ai[v]}, {3'h0, r[8:0]});
        end
    endtask
    // Main sequence: reset state, every format code, then the sense channels
    initial begin
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        rd(ADDR_SENSE_A, 8'h4c);
        rd(ADDR_SENSE_B, 8'h4c);
        rd(ADDR_SENSE_ENABLE, 8'h00);
        rd(8'h01, 8'h00);
        cfg({PWRDN_RESET, PWRDN_RESET, THRESH_RESET, THRESH_RESET});
        for (int c = 0; c < 32; c++) begin
            wr(ADDR_INPUT_FORMAT, 8'(c));
            repeat (2) @(negedge clk_sys);
            route(5'(c));
            rd(ADDR_INPUT_FORMAT, 8'(c));
        end
        // four-input component stays reserved, software muxes it
        wr(ADDR_INPUT_FORMAT, {3'h0, SEL_YPBPR});
        repeat (2) @(negedge clk_sys);
        chk("component", 12'(core[0]), 12'(FMT_NONE));
        chk("component", 12'(core[1]), 12'(FMT_COMPONENT));
        wr(ADDR_SENSE_ENABLE, 8'h03);
        wr(ADDR_SENSE_A, 8'h0c);
        wr(ADDR_SENSE_B, 8'h5c);
        // A powered with level 3, B powered down with level 7
        cfg(8'h5f);
        pulse(2'b11);
        rd(ADDR_SENSE_STATUS, 8'h01);
        chk("irq", 12'(irqn[0]), 12'h000);
        wr(ADDR_SENSE_STATUS, 8'h01);
        @(negedge clk_sys);
        chk("irq", 12'(irqn[1]), 12'h001);
        wr(ADDR_SENSE_B, 8'h00);
        pulse(2'b10);
        rd(ADDR_SENSE_STATUS, 8'h02);
        chk("irq", 12'(irqn[1]), 12'h000);
        rd(ADDR_SENSE_B, 8'h00);
        wr(ADDR_SENSE_STATUS, 8'h02);
        wr(ADDR_SENSE_ENABLE, 8'h00);
        pulse(2'b11);
        rd(ADDR_SENSE_STATUS, 8'h00);
        chk("irq", 12'(irqn[0]), 12'h001);
        clk_en = 1'b0;
        wr(ADDR_SENSE_A, 8'h5c);
        clk_en = 1'b1;
        rd(ADDR_SENSE_A, 8'h0c);
        // Reset in mid-run must drop the enable and restore defaults
        wr(ADDR_SENSE_ENABLE, 8'h03);
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        rd(ADDR_SENSE_ENABLE, 8'h00);
        cfg({PWRDN_RESET, PWRDN_RESET, THRESH_RESET, THRESH_RESET});
        route(5'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
